// ===== drc_pkg.sv
/*
  shared constants and carrier types for the digital i/o and reference
  configuration block. assumes a 100 MHz core clock.
*/
package drc_pkg;
  // register indices on the register port
  localparam logic [4:0] ADDR_PIN_STATE = 5'h05; // pin state and convert
  localparam logic [4:0] ADDR_PIN_DIR = 5'h06; // pin direction control
  localparam logic [4:0] ADDR_REF_OSC = 5'h07; // reference / oscillator config
  // field positions
  localparam int BIT_CONVERT_BUSY = 7; // convert_busy_flag
  localparam int NUM_PINS = 4; // digital pins
  // reset values
  localparam logic [3:0] RST_PIN_DIR = 4'h0; // all pins inputs
  localparam logic [3:0] RST_PIN_LATCH = 4'h0; // output latch cleared
  localparam logic [5:0] RST_REF_OSC = 6'h00; // everything powered down
  // timing: internal oscillator frequency and core clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_FREQ_KHZ = 2500;
  localparam int OSC_HALF_NS = 1000000 / (2 * OSC_FREQ_KHZ);
  localparam int OSC_HALF_CYC = (OSC_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : OSC_HALF_NS / CLK_PERIOD_NS;
  // falling conversion clock edges between a start write and the start
  localparam logic [1:0] START_FALLS = 2'h2;

  // reference voltage selection seen by the analog side
  typedef enum logic [1:0] {
    REF_2V500,
    REF_2V048,
    REF_1V150
  } drc_ref_level_type;

  // reference / oscillator register fields, bit 5 down to bit 0
  typedef struct packed {
    logic clk_src_sel; // ref_clock_source_select
    logic osc_en; // oscillator_enable_bit
    logic ref_en; // reference_enable_bit
    logic buf_en; // buffer_enable_bit
    logic two_volt; // two_volt_select
    logic bandgap; // bandgap_select
  } drc_ref_cfg_type;

  // register port request
  typedef struct packed {
    logic wr; // write strobe, one cycle, at the latching serial edge
    logic rd; // read sample strobe, one cycle
    logic [4:0] addr; // register index
    logic [7:0] wdata; // write byte
  } drc_reg_req_type;
endpackage : drc_pkg

// ===== drc_osc.sv
/*
  internal oscillator model: a 2.5 MHz square wave derived from the core
  clock while enabled. assumes the core clock rate named in the package.
*/
module drc_osc (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control and output
  input wire logic run_i,
  output logic osc_clk_o
);
  localparam logic [7:0] HALF = 8'(drc_pkg::OSC_HALF_CYC - 1);

  logic [7:0] cnt; // half-period counter
  logic [7:0] next_cnt;
  logic next_osc_clk;

  // stopped oscillator parks low so the pin never glitches on enable
  always_comb begin
    next_cnt = cnt;
    next_osc_clk = osc_clk_o;
    if (!run_i) begin
      next_cnt = 8'h00;
      next_osc_clk = 1'b0;
    end else if (cnt == HALF) begin
      next_cnt = 8'h00;
      next_osc_clk = ~osc_clk_o;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  // registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      osc_clk_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      osc_clk_o <= next_osc_clk;
    end
  end

  osc_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !run_i) |=> !osc_clk_o) else $error("oscillator not parked low");
endmodule : drc_osc

// ===== drc_clkdiv.sv
/*
  conversion clock divider: divides the sampled external clock level by
  1, 2, 4 or 8 and flags each falling edge of the result. the external
  clock must be slower than half the core clock.
*/
module drc_clkdiv (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // external clock and divide select
  input wire logic ext_clk_i,
  input wire logic [1:0] div_sel_i,
  // conversion clock
  output logic conv_clk_o,
  output logic conv_fall_o
);
  logic ext_q; // previous external level
  logic [2:0] cnt; // external rising edge count
  logic next_ext_q;
  logic [2:0] next_cnt;
  logic next_conv_clk;

  // pick the counter bit that gives the chosen division factor
  always_comb begin
    next_ext_q = ext_clk_i;
    next_cnt = (ext_clk_i && !ext_q) ? cnt + 3'h1 : cnt;
    case (div_sel_i)
      2'h0: next_conv_clk = ext_clk_i;
      2'h1: next_conv_clk = next_cnt[0];
      2'h2: next_conv_clk = next_cnt[1];
      2'h3: next_conv_clk = next_cnt[2];
      default: next_conv_clk = ext_clk_i;
    endcase
  end

  assign conv_fall_o = conv_clk_o && !next_conv_clk && ce_i;

  // registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_q <= 1'b0;
      cnt <= 3'h0;
      conv_clk_o <= 1'b0;
    end else if (ce_i) begin
      ext_q <= next_ext_q;
      cnt <= next_cnt;
      conv_clk_o <= next_conv_clk;
    end
  end

  div_one_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && div_sel_i == 2'h0) |=> conv_clk_o == $past(ext_clk_i)) else $error("undivided clock wrong");
endmodule : drc_clkdiv

// ===== drc_regs.sv
/*
  digital i/o and reference configuration registers (indices 5 to 7):
  four direction-programmable pins with pin readback, a conversion start
  and busy bit, and the reference / oscillator controls.
  assumes the serial engine issues one-cycle write and read strobes in the
  core clock domain and that the conversion engine reports busy.
*/
// Behaviour
// - input pin state follows pin, ignores writes
// - state read returns actual pin levels
// - start conversion on second conversion clock fall
// - busy flag reads conversion in progress
// - state bits 6 to 4 read zero
// - direction bit one drives pin from latch
// - reset: pins inputs, latch and busy zero
// - source select picks reference clock origin
// - oscillator enable drives 2.5 MHz on pin
// - reference enable powers the voltage reference
// - buffer enable powers the reference buffer
// - bandgap gives 1.15 V, else two-volt select
// - oscillator runs on pin, enable, or source-and-ref
// - conversion clock is external clock over 1/2/4/8
module drc_regs (
  // clock, reset and clock enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port from the serial engine
  input wire drc_pkg::drc_reg_req_type reg_req_i,
  output logic [7:0] reg_rdata_o,
  // digital i/o pins
  input wire logic [drc_pkg::NUM_PINS-1:0] dio_i,
  output logic [drc_pkg::NUM_PINS-1:0] dio_o,
  output logic [drc_pkg::NUM_PINS-1:0] dio_oe_o,
  // external clock pin
  input wire logic ext_clk_i,
  output logic ext_clk_o,
  output logic ext_clk_oe_o,
  // oscillator enable pin and clock divide field
  input wire logic oscillator_enable_pin_pin_i,
  input wire logic [1:0] clock_divide_field_i,
  // conversion engine
  input wire logic conv_busy_i,
  output logic conv_start_o,
  output logic conversion_clock_o,
  // analog controls
  output logic ref_clk_o,
  output logic osc_run_o,
  output logic ref_power_o,
  output logic buf_power_o,
  output drc_pkg::drc_ref_level_type ref_level_o
);
  typedef enum {
    ST_IDLE,
    ST_ARMED,
    ST_ONE_FALL
  } drc_start_type;

  localparam int NP = drc_pkg::NUM_PINS;

  logic [NP-1:0] pin_latch; // output latch
  logic [NP-1:0] pin_dir; // output_enable bits
  drc_pkg::drc_ref_cfg_type ref_cfg; // reference / oscillator fields
  drc_start_type start_st; // conversion start sequencer
  logic [NP-1:0] next_pin_latch;
  logic [NP-1:0] next_pin_dir;
  drc_pkg::drc_ref_cfg_type next_ref_cfg;
  drc_start_type next_start_st;
  logic next_conv_start;
  logic [7:0] next_rdata;
  logic osc_clk; // internal oscillator output
  logic conv_fall; // one-cycle flag per conversion clock falling edge
  logic busy_any; // pending start or conversion running
  logic wr_state; // write to pin state register
  logic wr_dir; // write to direction register
  logic wr_ref; // write to reference / oscillator register
  logic start_req; // write that asks for a conversion

  assign wr_state = reg_req_i.wr && reg_req_i.addr == drc_pkg::ADDR_PIN_STATE;
  assign wr_dir = reg_req_i.wr && reg_req_i.addr == drc_pkg::ADDR_PIN_DIR;
  assign wr_ref = reg_req_i.wr && reg_req_i.addr == drc_pkg::ADDR_REF_OSC;
  assign start_req = wr_state && reg_req_i.wdata[drc_pkg::BIT_CONVERT_BUSY];

  // output latch, one slice per pin; a pin set as input keeps its latch
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      always_comb begin
        next_pin_latch[gi] = pin_latch[gi];
        if (wr_state && pin_dir[gi]) begin
          next_pin_latch[gi] = reg_req_i.wdata[gi];
        end
      end
      assign dio_o[gi] = pin_latch[gi];
      assign dio_oe_o[gi] = pin_dir[gi];
    end
  endgenerate

  // configuration registers; reserved upper bits are simply not stored
  always_comb begin
    next_pin_dir = pin_dir;
    next_ref_cfg = ref_cfg;
    if (wr_dir) begin
      next_pin_dir = reg_req_i.wdata[NP-1:0];
    end
    if (wr_ref) begin
      next_ref_cfg = reg_req_i.wdata[5:0];
    end
  end

  // start sequencer: a new start write restarts the edge count, since the
  // count is defined from the serial edge that latched the byte
  always_comb begin
    next_start_st = start_st;
    next_conv_start = 1'b0;
    if (start_req) begin
      next_start_st = ST_ARMED;
    end else begin
      case (start_st)
        ST_IDLE: begin
          next_start_st = ST_IDLE;
        end
        ST_ARMED: begin
          if (conv_fall) begin
            next_start_st = ST_ONE_FALL;
          end
        end
        ST_ONE_FALL: begin
          if (conv_fall) begin
            next_start_st = ST_IDLE;
            next_conv_start = 1'b1;
          end
        end
        default: begin
          next_start_st = ST_IDLE;
        end
      endcase
    end
  end

  // busy covers the wait before the start so software never sees a gap
  assign busy_any = conv_busy_i || conv_start_o || start_st != ST_IDLE;

  // read mux, sampled on the read strobe; unmapped indices read zero
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        drc_pkg::ADDR_PIN_STATE: next_rdata = {busy_any, 3'h0, dio_i};
        drc_pkg::ADDR_PIN_DIR: next_rdata = {4'h0, pin_dir};
        drc_pkg::ADDR_REF_OSC: next_rdata = {2'h0, ref_cfg};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_latch <= drc_pkg::RST_PIN_LATCH;
      pin_dir <= drc_pkg::RST_PIN_DIR;
      ref_cfg <= drc_pkg::RST_REF_OSC;
      start_st <= ST_IDLE;
      conv_start_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      pin_latch <= next_pin_latch;
      pin_dir <= next_pin_dir;
      ref_cfg <= next_ref_cfg;
      start_st <= next_start_st;
      conv_start_o <= next_conv_start;
      reg_rdata_o <= next_rdata;
    end
  end

  // oscillator runs for any of three causes; only the enable bit drives the pin
  assign osc_run_o = oscillator_enable_pin_pin_i || ref_cfg.osc_en || (ref_cfg.clk_src_sel && ref_cfg.ref_en);
  assign ext_clk_oe_o = ref_cfg.osc_en;
  assign ext_clk_o = osc_clk;

  drc_osc drc_osc_i (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(osc_run_o),
    .osc_clk_o(osc_clk)
  );

  // while the oscillator drives the pin, the pin level is the oscillator
  drc_clkdiv drc_clkdiv_i (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ext_clk_i(ext_clk_oe_o ? osc_clk : ext_clk_i),
    .div_sel_i(clock_divide_field_i),
    .conv_clk_o(conversion_clock_o),
    .conv_fall_o(conv_fall)
  );

  // reference clock: divided pin clock or the internal oscillator
  assign ref_clk_o = ref_cfg.clk_src_sel ? osc_clk : conversion_clock_o;
  assign ref_power_o = ref_cfg.ref_en;
  assign buf_power_o = ref_cfg.buf_en;

  // bandgap select overrides the two-volt select
  always_comb begin
    if (ref_cfg.bandgap) begin
      ref_level_o = drc_pkg::REF_1V150;
    end else if (ref_cfg.two_volt) begin
      ref_level_o = drc_pkg::REF_2V048;
    end else begin
      ref_level_o = drc_pkg::REF_2V500;
    end
  end

  // helper: conversion clock falls seen since the last start write
  logic [1:0] falls_seen;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      falls_seen <= 2'h0;
    end else if (ce_i) begin
      if (start_req) begin
        falls_seen <= 2'h0;
      end else if (conv_fall && falls_seen != 2'h3) begin
        falls_seen <= falls_seen + 2'h1;
      end
    end
  end

  sequence start_wr_s;
    ce_i && start_req;
  endsequence

  sequence quiet_s;
    ce_i && !conv_fall && !start_req;
  endsequence

  start_count_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conv_start_o |-> falls_seen == drc_pkg::START_FALLS) else $error("start not on second fall");
  start_wait_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_wr_s ##1 quiet_s |=> !conv_start_o && busy_any) else $error("start fired early");
  pin_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && reg_req_i.addr == drc_pkg::ADDR_PIN_STATE)
    |=> reg_rdata_o[3:0] == $past(dio_i) && reg_rdata_o[6:4] == 3'h0) else $error("pin read wrong");
  busy_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && reg_req_i.addr == drc_pkg::ADDR_PIN_STATE)
    |=> reg_rdata_o[7] == $past(busy_any)) else $error("busy read wrong");
  input_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_state && pin_dir == 4'h0) |=> $stable(dio_o) && dio_oe_o == 4'h0) else $error("input bit written");
  out_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_state) |=> (dio_o & $past(pin_dir)) == ($past(reg_req_i.wdata[3:0]) & $past(pin_dir)))
    else $error("output latch not updated");
  dir_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_dir) |=> dio_oe_o == $past(reg_req_i.wdata[3:0])) else $error("direction not taken");
  reset_state_a: assert property (@(posedge core_clk_i)
    rst_i |-> dio_oe_o == 4'h0 && dio_o == 4'h0 && start_st == ST_IDLE && !conv_start_o)
    else $error("reset values wrong");
  clk_pin_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_ref) |=> ext_clk_oe_o == $past(reg_req_i.wdata[4])
    && osc_run_o == (oscillator_enable_pin_pin_i || $past(reg_req_i.wdata[4])
    || ($past(reg_req_i.wdata[5]) && $past(reg_req_i.wdata[3]))))
    else $error("clock pin control wrong");
  power_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_ref) |=> ref_power_o == $past(reg_req_i.wdata[3]) && buf_power_o == $past(reg_req_i.wdata[2]))
    else $error("power control wrong");
  ref_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_ref && reg_req_i.wdata[0]) |=> ref_level_o == drc_pkg::REF_1V150) else $error("bandgap not chosen");
  ref_src_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ref_cfg.clk_src_sel |-> ref_clk_o == osc_clk) else $error("reference clock source wrong");

  // a start pulse lasts one core cycle, so one write can never start two conversions
  start_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && conv_start_o) |=> !conv_start_o) else $error("start pulse too long");
  // the start write itself never fires the engine; counting begins afresh
  start_restart_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_wr_s |=> !conv_start_o) else $error("start fired on its own write");
  // busy must read 1 straight after a start write, before the engine reacts
  busy_pend_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_wr_s |=> busy_any) else $error("busy gap after start write");
  // direction readback shows the drive enables with the reserved bits clear
  dir_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && reg_req_i.addr == drc_pkg::ADDR_PIN_DIR)
    |=> reg_rdata_o == {4'h0, $past(dio_oe_o)}) else $error("direction read wrong");
  // reference readback agrees with the power outputs that it controls
  ref_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && reg_req_i.addr == drc_pkg::ADDR_REF_OSC)
    |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3] == $past(ref_power_o)
    && reg_rdata_o[2] == $past(buf_power_o)) else $error("reference read wrong");
  // the two upper reference levels when the bandgap is off
  ref_two_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_ref && !reg_req_i.wdata[0])
    |=> ref_level_o == ($past(reg_req_i.wdata[1]) ? drc_pkg::REF_2V048 : drc_pkg::REF_2V500))
    else $error("reference level wrong");
  // the outside enable pin alone keeps the oscillator running
  osc_pin_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    oscillator_enable_pin_pin_i |-> osc_run_o) else $error("oscillator pin ignored");
  // a driven clock pin carries a running oscillator
  clk_drive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ext_clk_oe_o |-> ext_clk_o == osc_clk && osc_run_o) else $error("clock pin not driven by oscillator");
  // the latch moves only on a state write
  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !wr_state) |=> $stable(dio_o)) else $error("latch changed without write");
  // a low clock enable holds every registered output
  freeze_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(dio_o) && $stable(dio_oe_o) && $stable(reg_rdata_o) && $stable(conv_start_o))
    else $error("state moved while frozen");
endmodule : drc_regs

// ===== drc_host.sv
/*
  host model for the register port: issues one-cycle write and read strobes.
  assumes strobes are launched after a falling core clock edge and held
  across exactly one rising edge, as the serial engine would issue them.
*/
module drc_host (
  // clock
  input wire logic core_clk_i,
  // request to the register port
  output drc_pkg::drc_reg_req_type reg_req_o,
  // read byte back
  input wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;

  int idle_gap = 0; // extra idle cycles before a request, for a slow host

  // port idle from time zero so nothing is taken during reset
  initial begin
    reg_req_o = '0;
  end

  // one write strobe; reserved bits of the direction and reference registers are cleared before they leave the host
  task automatic wr_reg(input logic [4:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == drc_pkg::ADDR_PIN_DIR) d[7:4] = 4'h0;
    if (addr == drc_pkg::ADDR_REF_OSC) d[7:6] = 2'h0;
    repeat (idle_gap + 1) @(negedge core_clk_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
    @(negedge core_clk_i);
    reg_req_o <= '0;
  endtask : wr_reg

  // one read strobe; the byte is registered at the taking edge
  task automatic rd_reg(input logic [4:0] addr, output logic [7:0] data);
    repeat (idle_gap + 1) @(negedge core_clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge core_clk_i);
    reg_req_o <= '0;
    data = reg_rdata_i;
  endtask : rd_reg
endmodule : drc_host

// ===== drc_regs_tb.sv
/*
  self-checking bench for the pin, convert and reference registers.
  assumes the host model drives the register port; the bench plays the
  outside pins, the clock pin source and the conversion engine.
*/
module drc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and bench-driven inputs
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [3:0] pin_drive = 4'h0; // level from outside circuitry
  logic ext_src = 1'b0; // outside clock on the clock pin
  logic osc_pin = 1'b0;
  logic [1:0] div_field = 2'h0;
  logic conv_busy = 1'b0;
  // design side
  drc_pkg::drc_reg_req_type req;
  logic [7:0] rdata;
  logic [3:0] dio, dio_o, dio_oe;
  logic ext_clk, ext_clk_o, ext_clk_oe, conv_start, conv_clk, ref_clk, osc_run, ref_pw, buf_pw;
  drc_pkg::drc_ref_level_type ref_level;
  // bookkeeping
  int failures = 0, n_tests = 0, cycles = 0, falls = 0, nbad;
  logic armed = 1'b0, started = 1'b0, prev_cc = 1'b0;
  realtime t0;

  // resolved wires: a driven pin shows the latch, otherwise the outside level
  assign dio = (dio_oe & dio_o) | (~dio_oe & pin_drive);
  assign ext_clk = ext_clk_oe ? ext_clk_o : ext_src;

  always #5 core_clk_i = ~core_clk_i;

  drc_regs drc_regs_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .dio_i(dio), .dio_o(dio_o), .dio_oe_o(dio_oe), .ext_clk_i(ext_clk), .ext_clk_o(ext_clk_o),
    .ext_clk_oe_o(ext_clk_oe), .oscillator_enable_pin_pin_i(osc_pin), .clock_divide_field_i(div_field),
    .conv_busy_i(conv_busy), .conv_start_o(conv_start), .conversion_clock_o(conv_clk),
    .ref_clk_o(ref_clk), .osc_run_o(osc_run), .ref_power_o(ref_pw), .buf_power_o(buf_pw),
    .ref_level_o(ref_level)
  );
  drc_host drc_host_i (.core_clk_i(core_clk_i), .reg_req_o(req), .reg_rdata_i(rdata));

  // compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // read through the host and compare
  task automatic rchk(input string name, input logic [4:0] addr, input logic [7:0] exp);
    logic [7:0] seen;
    drc_host_i.rd_reg(addr, seen);
    chk(name, seen, exp);
  endtask : rchk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // outside clock of 16 cycles, start-edge watcher and hang limit
  always @(negedge core_clk_i) begin
    cycles++;
    if (cycles % 8 == 0) ext_src <= ~ext_src;
    if (armed && prev_cc && !conv_clk) falls++;
    if (armed && conv_start) begin
      chk("start_falls", 8'(falls), 8'h02);
      armed = 1'b0;
      started = 1'b1;
    end
    prev_cc = conv_clk;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // main sequence
  initial begin
    // raise reset off the clock edge so every flop is cleared before the first edge
    #1 rst_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    rst_i = 1'b0;
    pin_drive = 4'hA;
    rchk("state_reset", 5'h05, 8'h0A);
    rchk("dir_reset", 5'h06, 8'h00);
    rchk("refosc_reset", 5'h07, 8'h00);
    chk("oe_reset", 8'(dio_oe), 8'h00);
    // a frozen port drops the write; unmapped reads give zero
    ce_i = 1'b0;
    drc_host_i.wr_reg(5'h06, 8'h0F);
    ce_i = 1'b1;
    rchk("dir_frozen", 5'h06, 8'h00);
    drc_host_i.idle_gap = 3;
    rchk("unmapped", 5'h08, 8'h00);
    drc_host_i.idle_gap = 0;
    // pins 0 and 2 driven, 1 and 3 stay inputs
    pin_drive = 4'h0;
    drc_host_i.wr_reg(5'h06, 8'h05);
    chk("oe_set", 8'(dio_oe), 8'h05);
    drc_host_i.wr_reg(5'h05, 8'h7F);
    rchk("state_out", 5'h05, 8'h05);
    chk("latch_out", 8'(dio_o & dio_oe), 8'h05);
    pin_drive = 4'hF;
    drc_host_i.wr_reg(5'h05, 8'h00);
    rchk("state_mix", 5'h05, 8'h0A);
    // turning every pin to output must not reveal the ignored input bits
    drc_host_i.wr_reg(5'h06, 8'h0F);
    rchk("state_latch", 5'h05, 8'h00);
    rchk("dir_rb", 5'h06, 8'h0F);
    // reference level for all four select codes
    for (int i = 0; i < 4; i++) begin
      drc_host_i.wr_reg(5'h07, 8'(i));
      chk("ref_level", 8'(ref_level), i[0] ? 8'(drc_pkg::REF_1V150) :
          (i[1] ? 8'(drc_pkg::REF_2V048) : 8'(drc_pkg::REF_2V500)));
    end
    drc_host_i.wr_reg(5'h07, 8'h0C);
    chk("powers", {6'h00, ref_pw, buf_pw}, 8'h03);
    rchk("refosc_rb", 5'h07, 8'h0C);
    drc_host_i.wr_reg(5'h07, 8'h28);
    chk("osc_src_ref", {6'h00, osc_run, ext_clk_oe}, 8'h02);
    drc_host_i.wr_reg(5'h07, 8'h20);
    chk("osc_off", {6'h00, osc_run, ext_clk_oe}, 8'h00);
    osc_pin = 1'b1;
    @(negedge core_clk_i);
    chk("osc_pin", {6'h00, osc_run, ext_clk_oe}, 8'h02);
    osc_pin = 1'b0;
    // oscillator drives the clock pin and feeds the reference clock
    drc_host_i.wr_reg(5'h07, 8'h30);
    chk("osc_drive", {6'h00, osc_run, ext_clk_oe}, 8'h03);
    @(posedge ext_clk_o);
    t0 = $realtime;
    @(posedge ext_clk_o);
    chk("osc_period", 8'(int'(($realtime - t0) / 10.0)), 8'(2 * drc_pkg::OSC_HALF_CYC));
    nbad = 0;
    repeat (100) begin
      @(negedge core_clk_i);
      nbad += int'(ref_clk !== ext_clk_o);
    end
    chk("ref_clk_osc", 8'(nbad), 8'h00);
    // divided conversion clock for every divide code
    drc_host_i.wr_reg(5'h07, 8'h00);
    for (int d = 0; d < 4; d++) begin
      div_field = 2'(d);
      repeat (300) @(negedge core_clk_i);
      @(posedge conv_clk);
      t0 = $realtime;
      @(posedge conv_clk);
      chk("div_period", 8'(int'(($realtime - t0) / 10.0)), 8'(16 << d));
    end
    nbad = 0;
    repeat (200) begin
      @(negedge core_clk_i);
      nbad += int'(ref_clk !== conv_clk);
    end
    chk("ref_clk_pin", 8'(nbad), 8'h00);
    // start well away from a falling edge so the count is unambiguous
    @(posedge conv_clk);
    drc_host_i.wr_reg(5'h05, 8'h80);
    falls = 0;
    armed = 1'b1;
    rchk("busy_pending", 5'h05, 8'h80);
    nbad = 0;
    while (!started && nbad < 1000) begin
      @(negedge core_clk_i);
      nbad++;
    end
    chk("start_seen", 8'(started), 8'h01);
    conv_busy = 1'b1;
    rchk("busy_conv", 5'h05, 8'h80);
    conv_busy = 1'b0;
    @(negedge core_clk_i);
    rchk("busy_idle", 5'h05, 8'h00);
    print_verdict();
  end
endmodule : drc_regs_tb
